// file: rtl/tcwp_defines.svh
// offsets, field positions, reset values and timing counts of the timer block
`ifndef TCWP_DEFINES_SVH
`define TCWP_DEFINES_SVH
// ----------------------------------------
// register indices, byte address = 4 * index
// ----------------------------------------
`define TCWP_IDX_COUNT 8'h01
`define TCWP_IDX_CONFIG 8'h81
`define TCWP_IDX_IRQ 8'h0B
// ----------------------------------------
// field positions
// ----------------------------------------
`define TCWP_CFG_SOURCE 5
`define TCWP_CFG_EDGE 4
`define TCWP_CFG_ASSIGN 3
`define TCWP_IRQ_ENABLE 5
`define TCWP_IRQ_FLAG 2
// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define TCWP_CFG_RESET 8'hFF
`define TCWP_WR_INHIBIT 2'h2
`define TCWP_PHASE_SECOND 2'h1
`define TCWP_PHASE_FOURTH 2'h3
`define TCWP_RESP_OKAY 2'h0
`define TCWP_RESP_SLVERR 2'h2
`endif

// file: rtl/tcwp_pkg.sv
// types of the timer block
package tcwp_pkg;
  typedef struct packed {
    logic awvalid;
    logic [11:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [11:0] araddr;
    logic rready;
  } tcwp_axi_req_s;
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } tcwp_axi_rsp_s;
  typedef struct packed {
    logic [1:0] phase;
    logic [7:0] count;
    logic [7:0] cfg;
    logic ie;
    logic flag;
    logic [1:0] inhib;
    logic [7:0] presc;
    logic pin_prev;
    logic samp;
    logic pend;
    logic post_tick;
    logic irq;
    logic aw_ok;
    logic [7:0] aw_idx;
    logic w_ok;
    logic [7:0] wdata;
    logic wstb;
    tcwp_axi_rsp_s rsp;
  } tcwp_state_s;
endpackage : tcwp_pkg

// file: rtl/tcwp_timer.sv
// timer/counter with shared prescaler and register slave
`timescale 1ns/1ns
`include "tcwp_defines.svh"

// Behaviour
// R1: timer mode without prescaler counts once per instruction cycle
// R2: a count write blocks counting for the next two instruction cycles
// R3: counter mode counts edges of the external count input
// R4: edge select clear counts rising edges, set counts falling edges
// R5: one prescaler, assigned to timer when clear, watchdog when set
// R6: timer ratios 1:2 up to 1:256 in powers of two
// R7: prescaler value can be neither read nor loaded by software
// R8: wrap from FFh to 00h sets the overflow flag
// R9: interrupt raised only with enable bit 5 set; flag at bit 2
// R10: software clears the flag before re-enabling; hardware never clears it
// R11: no counting during sleep, so no overflow wake-up
// R12: count source sampled on second and fourth phase
// R13: unscaled external input high and low at least two clock periods
// R14: scaled external input period at least four clocks over the ratio
// R15: external edge to increment takes three to seven clock periods
// R16: prescaler is an 8-bit counter with a symmetrical divided output
// R17: count write clears the prescaler while assigned to the timer
// R18: watchdog clear clears the prescaler while assigned to the watchdog
// R19: software clears watchdog and prescaler before moving the assignment
// R20: ratio codes 000 to 111 give 1:2 through 1:256; the watchdog post tick divides 1:1 through 1:128 instead
// R21: assignment change takes effect at once without halting counting
module tcwp_timer
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // register bus
  input tcwp_pkg::tcwp_axi_req_s axi_req,
  output tcwp_pkg::tcwp_axi_rsp_s axi_rsp,
  // pins and core events
  input wire logic ext_count_input,
  input wire logic sleep_mode,
  input wire logic watchdog_tick,
  input wire logic watchdog_clear,
  // results
  output logic overflow_irq,
  output logic watchdog_post_tick
);
  import tcwp_pkg::*;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic is_mapped(input logic [7:0] idx);
    is_mapped = (idx == `TCWP_IDX_COUNT) || (idx == `TCWP_IDX_CONFIG) || (idx == `TCWP_IDX_IRQ);
  endfunction : is_mapped

  function automatic logic [7:0] low_mask(input logic [2:0] ratio);
    low_mask = 8'(({8'h00, 8'hFF} >> (5'd8 - {2'h0, ratio})));
  endfunction : low_mask

  tcwp_state_s st_r;
  tcwp_state_s st_nxt;
  logic q2;
  logic q4;
  logic to_timer;
  logic ext_mode;
  logic lvl_pin;
  logic src_lvl;
  logic presc_clk;
  logic rise;
  logic inc;
  logic inc_ok;
  logic do_wr;
  logic wr_count;
  logic wr_cfg;
  logic wr_irq;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    q2 = st_r.phase == `TCWP_PHASE_SECOND;
    q4 = st_r.phase == `TCWP_PHASE_FOURTH;
    to_timer = !st_r.cfg[`TCWP_CFG_ASSIGN];
    ext_mode = st_r.cfg[`TCWP_CFG_SOURCE];
    lvl_pin = ext_count_input ^ st_r.cfg[`TCWP_CFG_EDGE]; // R4
    rise = 1'b0;
    inc = 1'b0;
    // bus capture
    if (axi_req.awvalid && st_r.rsp.awready)
    begin
      st_nxt.aw_ok = 1'b1;
      st_nxt.aw_idx = axi_req.awaddr[9:2];
    end
    if (axi_req.wvalid && st_r.rsp.wready)
    begin
      st_nxt.w_ok = 1'b1;
      st_nxt.wdata = axi_req.wdata[7:0];
      st_nxt.wstb = axi_req.wstrb[0];
    end
    if (st_r.rsp.bvalid && axi_req.bready)
      st_nxt.rsp.bvalid = 1'b0;
    do_wr = st_r.aw_ok && st_r.w_ok && !st_r.rsp.bvalid;
    wr_count = do_wr && st_r.wstb && (st_r.aw_idx == `TCWP_IDX_COUNT);
    wr_cfg = do_wr && st_r.wstb && (st_r.aw_idx == `TCWP_IDX_CONFIG);
    wr_irq = do_wr && st_r.wstb && (st_r.aw_idx == `TCWP_IDX_IRQ);
    if (do_wr)
    begin
      st_nxt.aw_ok = 1'b0;
      st_nxt.w_ok = 1'b0;
      st_nxt.rsp.bvalid = 1'b1;
      st_nxt.rsp.bresp = is_mapped(st_r.aw_idx) ? `TCWP_RESP_OKAY : `TCWP_RESP_SLVERR;
    end
    // reads, prescaler never visible
    if (axi_req.arvalid && st_r.rsp.arready)
    begin
      st_nxt.rsp.rvalid = 1'b1;
      st_nxt.rsp.rresp = is_mapped(axi_req.araddr[9:2]) ? `TCWP_RESP_OKAY : `TCWP_RESP_SLVERR;
      st_nxt.rsp.rdata = 32'h0000_0000;
      case (axi_req.araddr[9:2])
        `TCWP_IDX_COUNT: st_nxt.rsp.rdata[7:0] = st_r.count;
        `TCWP_IDX_CONFIG: st_nxt.rsp.rdata[7:0] = st_r.cfg;
        `TCWP_IDX_IRQ:
        begin
          st_nxt.rsp.rdata[`TCWP_IRQ_ENABLE] = st_r.ie;
          st_nxt.rsp.rdata[`TCWP_IRQ_FLAG] = st_r.flag;
        end
        default: st_nxt.rsp.rdata = 32'h0000_0000;
      endcase
    end
    else if (st_r.rsp.rvalid && axi_req.rready)
      st_nxt.rsp.rvalid = 1'b0;
    // phase counter, one instruction cycle per four clocks
    st_nxt.phase = st_r.phase + 2'h1;
    // prescaler clocking
    st_nxt.pin_prev = lvl_pin;
    if (to_timer) // R5 R21
      presc_clk = ext_mode ? (lvl_pin && !st_r.pin_prev) : q4;
    else
      presc_clk = watchdog_tick;
    if (presc_clk && !(to_timer && sleep_mode)) // R16 R11
      st_nxt.presc = st_r.presc + 8'h01;
    st_nxt.post_tick = !to_timer && watchdog_tick
      && ((st_r.presc & low_mask(st_r.cfg[2:0])) == low_mask(st_r.cfg[2:0]));
    if ((to_timer && wr_count) || (!to_timer && watchdog_clear))
      st_nxt.presc = 8'h00; // R17 R18 R7
    // count source and phase sampling
    src_lvl = to_timer ? st_r.presc[st_r.cfg[2:0]] : lvl_pin; // R6 R20
    if (!to_timer && !ext_mode)
      inc = q4; // R1
    else
    begin
      if (q2 || q4)
      begin
        st_nxt.samp = src_lvl; // R12
        rise = src_lvl && !st_r.samp; // R3
      end
      if (q4)
      begin
        inc = st_r.pend; // R15
        st_nxt.pend = rise;
      end
      else if (rise)
        st_nxt.pend = 1'b1;
    end
    inc_ok = inc && !sleep_mode && (st_r.inhib == 2'h0); // R11 R2
    if (q4 && (st_r.inhib != 2'h0))
      st_nxt.inhib = st_r.inhib - 2'h1;
    if (inc_ok)
      st_nxt.count = st_r.count + 8'h01;
    // register writes
    if (wr_count)
    begin
      st_nxt.count = st_r.wdata;
      st_nxt.inhib = `TCWP_WR_INHIBIT; // R2
    end
    if (wr_cfg)
      st_nxt.cfg = st_r.wdata; // R21
    if (wr_irq)
    begin
      st_nxt.ie = st_r.wdata[`TCWP_IRQ_ENABLE];
      st_nxt.flag = st_r.wdata[`TCWP_IRQ_FLAG];
    end
    if (inc_ok && (st_r.count == 8'hFF))
      st_nxt.flag = 1'b1; // R8
    st_nxt.irq = st_nxt.flag && st_nxt.ie; // R9
    st_nxt.rsp.awready = !st_nxt.aw_ok && !st_nxt.rsp.bvalid;
    st_nxt.rsp.wready = !st_nxt.w_ok && !st_nxt.rsp.bvalid;
    st_nxt.rsp.arready = !st_nxt.rsp.rvalid;
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_r <= '0;
      st_r.cfg <= `TCWP_CFG_RESET;
      // idle level of the edge path after reset, no false edge
      st_r.samp <= 1'b1;
      st_r.pin_prev <= 1'b1;
      st_r.rsp.awready <= 1'b1;
      st_r.rsp.wready <= 1'b1;
      st_r.rsp.arready <= 1'b1;
    end
    else
      st_r <= st_nxt;
  end

  assign axi_rsp = st_r.rsp;
  assign overflow_irq = st_r.irq;
  assign watchdog_post_tick = st_r.post_tick;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence s_count_write;
    do_wr && st_r.wstb && (st_r.aw_idx == `TCWP_IDX_COUNT);
  endsequence

  sequence s_ext_rise;
    ext_mode && !st_r.cfg[`TCWP_CFG_ASSIGN] == 1'b0 && !sleep_mode && (st_r.inhib == 2'h0)
      && !st_r.samp && lvl_pin ##1 lvl_pin && !do_wr ##1 lvl_pin && !do_wr;
  endsequence

  a_timer_tick: assert property (q4 && !to_timer && !ext_mode && !sleep_mode // R1
    && (st_r.inhib == 2'h0) && !do_wr |=> st_r.count == 8'($past(st_r.count) + 8'h01))
    else $error("timer did not count on instruction cycle");

  a_write_inhibit: assert property (s_count_write |=> (st_r.inhib == 2'h2) // R2
    && (st_r.count == $past(st_r.wdata)))
    else $error("count write did not start inhibit");

  a_inhibit_block: assert property ((st_r.inhib != 2'h0) && !do_wr |=> $stable(st_r.count)) // R2
    else $error("count moved while inhibited");

  a_ext_latency: assert property (s_ext_rise |-> ##[0:5] (st_r.count != $past(st_r.count))) // R15
    else $error("external edge not counted in time");

  a_overflow_flag: assert property ((st_r.count == 8'hFF) && inc_ok |=> st_r.flag // R8
    && (st_r.count == 8'h00))
    else $error("overflow did not set flag");

  a_irq_gate: assert property (overflow_irq |-> st_r.ie && st_r.flag) // R9
    else $error("interrupt raised while masked");

  a_sleep_hold: assert property (sleep_mode && !do_wr |=> $stable(st_r.count)) // R11
    else $error("timer counted during sleep");

  a_presc_clr_wr: assert property (s_count_write and to_timer |=> st_r.presc == 8'h00) // R17
    else $error("prescaler not cleared by count write");

  a_presc_clr_wd: assert property (watchdog_clear && !to_timer |=> st_r.presc == 8'h00) // R18
    else $error("prescaler not cleared by watchdog clear");

  a_post_exclusive: assert property (watchdog_post_tick |-> $past(st_r.cfg[`TCWP_CFG_ASSIGN])) // R5
    else $error("post tick while assigned to timer");

  // ----------------------------------------
  // prescaler, sampling and inhibit checks
  // ----------------------------------------

  a_wd_hold: assert property (!to_timer && !watchdog_tick && !watchdog_clear // R5
    |=> $stable(st_r.presc))
    else $error("watchdog prescaler moved without a tick");

  a_timer_post: assert property (to_timer // R5
    |=> !watchdog_post_tick)
    else $error("post tick while prescaler serves timer");

  a_presc_step: assert property (to_timer && !ext_mode && q4 && !sleep_mode && !wr_count // R16
    |=> st_r.presc == 8'($past(st_r.presc) + 8'h01))
    else $error("prescaler did not step on instruction cycle");

  a_sample_phase: assert property ((to_timer || ext_mode) && !q2 && !q4 // R12
    |=> $stable(st_r.samp))
    else $error("source sampled outside second and fourth phase");

  a_sleep_presc: assert property (sleep_mode && to_timer && !wr_count // R11
    |=> $stable(st_r.presc))
    else $error("timer prescaler moved during sleep");

  a_inhib_step: assert property (q4 && (st_r.inhib != 2'h0) && !wr_count // R2
    |=> st_r.inhib == 2'($past(st_r.inhib) - 2'h1))
    else $error("inhibit did not count down");

  // ----------------------------------------
  // register checks
  // ----------------------------------------

  a_flag_sticky: assert property (st_r.flag && !wr_irq // R10
    |=> st_r.flag)
    else $error("overflow flag cleared by hardware");

  a_cfg_write: assert property (wr_cfg // R21
    |=> st_r.cfg == $past(st_r.wdata))
    else $error("config write not applied at once");

  a_irq_write: assert property (wr_irq // R9
    |=> st_r.ie == $past(st_r.wdata[`TCWP_IRQ_ENABLE]))
    else $error("interrupt enable write not applied");

  a_read_upper: assert property (st_r.rsp.rvalid // R7
    |-> st_r.rsp.rdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");

  // ----------------------------------------
  // bus checks
  // ----------------------------------------

  sequence s_both_taken;
    st_r.aw_ok && st_r.w_ok && !st_r.rsp.bvalid;
  endsequence

  a_write_answer: assert property (s_both_taken
    |=> st_r.rsp.bvalid)
    else $error("write response missing");

  a_read_answer: assert property (axi_req.arvalid && st_r.rsp.arready
    |=> st_r.rsp.rvalid)
    else $error("read response missing");

  a_bresp_hold: assert property (st_r.rsp.bvalid && !axi_req.bready
    |=> st_r.rsp.bvalid && $stable(st_r.rsp.bresp))
    else $error("write response dropped before taken");

  a_rdata_hold: assert property (st_r.rsp.rvalid && !axi_req.rready
    |=> st_r.rsp.rvalid && $stable(st_r.rsp.rdata))
    else $error("read data dropped before taken");

  a_aw_refuse: assert property (st_r.rsp.bvalid
    |-> !st_r.rsp.awready && !st_r.rsp.wready)
    else $error("write accepted while response pending");

  a_ar_refuse: assert property (st_r.rsp.rvalid
    |-> !st_r.rsp.arready)
    else $error("read accepted while data pending");
endmodule : tcwp_timer

// file: test/tcwp_pin_src.sv
// model of the source that drives the external count pin
`timescale 1ns/1ns
module tcwp_pin_src
(
  // clock
  input wire logic clk,
  // command
  input wire logic go,
  input wire logic [3:0] toggles,
  input wire logic slow,
  // pin and status
  output logic pin,
  output logic busy
);
  // ----
  // level changes
  // ----
  initial
  begin
    pin = 1'h0;
    busy = 1'h0;
  end
  always @(posedge clk)
  begin
    if (go)
    begin
      busy <= 1'h1;
      repeat (toggles)
      begin
        repeat (slow ? 9 : 2) @(posedge clk);
        pin <= ~pin;
      end
      @(posedge clk);
      busy <= 1'h0;
    end
  end
endmodule : tcwp_pin_src

// file: test/tcwp_timer_bench.sv
// self-checking bench of the timer block
`timescale 1ns/1ns
`include "tcwp_defines.svh"
module tcwp_timer_bench;
  import tcwp_pkg::*;
  // ----
  // signals
  // ----
  localparam logic [11:0] adr_cnt = {2'h0, `TCWP_IDX_COUNT, 2'h0};
  localparam logic [11:0] adr_cfg = {2'h0, `TCWP_IDX_CONFIG, 2'h0};
  localparam logic [11:0] adr_irq = {2'h0, `TCWP_IDX_IRQ, 2'h0};
  logic clk, nrst, sleep_mode, watchdog_tick, watchdog_clear, overflow_irq, watchdog_post_tick;
  logic ext_pin, go, slow, busy;
  logic [3:0] toggles;
  logic [31:0] rdat;
  logic [1:0] resp;
  logic [7:0] first;
  tcwp_axi_req_s req;
  tcwp_axi_rsp_s rsp;
  int fail_count, checked, posts;
  tcwp_timer tcwp_timer_inst (.clk(clk), .nrst(nrst), .axi_req(req), .axi_rsp(rsp),
    .ext_count_input(ext_pin), .sleep_mode(sleep_mode), .watchdog_tick(watchdog_tick),
    .watchdog_clear(watchdog_clear), .overflow_irq(overflow_irq), .watchdog_post_tick(watchdog_post_tick));
  tcwp_pin_src tcwp_pin_src_inst (.clk(clk), .go(go), .toggles(toggles), .slow(slow), .pin(ext_pin), .busy(busy));
  initial
  begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) if (watchdog_post_tick === 1'h1) posts <= posts + 1;
  // ----
  // bus, compare and stimulus tasks
  // ----
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    req.awaddr <= a;
    req.wdata <= {24'h0, d};
    req.wstrb <= 4'hF;
    req.awvalid <= 1'h1;
    req.wvalid <= 1'h1;
    req.bready <= 1'h1;
    do
    begin
      @(posedge clk);
      if (rsp.awready) req.awvalid <= 1'h0;
      if (rsp.wready) req.wvalid <= 1'h0;
    end
    while (rsp.bvalid !== 1'h1);
    resp = rsp.bresp;
    req.bready <= 1'h0;
  endtask : wr
  task automatic rd(input logic [11:0] a);
    @(posedge clk);
    req.araddr <= a;
    req.arvalid <= 1'h1;
    req.rready <= 1'h1;
    do
    begin
      @(posedge clk);
      if (rsp.arready) req.arvalid <= 1'h0;
    end
    while (rsp.rvalid !== 1'h1);
    rdat = rsp.rdata;
    resp = rsp.rresp;
    req.rready <= 1'h0;
  endtask : rd
  task automatic check_eq(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_eq
  task automatic check_rng(input logic [7:0] got, input int lo, input int hi);
    checked++;
    if ($isunknown(got) || int'(got) < lo || int'(got) > hi)
    begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask : check_rng
  task automatic rchk(input logic [11:0] a, input logic [31:0] d);
    rd(a);
    check_eq(rdat, d);
  endtask : rchk
  task automatic pulses(input logic [3:0] n, input logic s);
    toggles <= n;
    slow <= s;
    go <= 1'h1;
    @(posedge clk);
    go <= 1'h0;
    do @(posedge clk);
    while (busy);
    repeat (8) @(posedge clk);
  endtask : pulses
  task automatic tick(input int n);
    repeat (n)
    begin
      watchdog_tick <= 1'h1;
      @(posedge clk);
      watchdog_tick <= 1'h0;
      @(posedge clk);
    end
    repeat (4) @(posedge clk);
  endtask : tick
  // ----
  // scenarios
  // ----
  task automatic t_reset();
    rchk(adr_cfg, 32'hFF);
    rchk(adr_cnt, 32'h0);
    rchk(adr_irq, 32'h0);
    rchk(12'hFFC, 32'h0);
    check_eq(resp, `TCWP_RESP_SLVERR);
    $display("done reset");
  endtask : t_reset
  task automatic t_timer();
    wr(adr_cfg, 8'h08);
    wr(adr_cnt, 8'h10);
    repeat (4) @(posedge clk);
    rd(adr_cnt);
    check_rng(rdat[7:0], 16, 17);
    first = rdat[7:0];
    repeat (400) @(posedge clk);
    rd(adr_cnt);
    check_rng(rdat[7:0] - first, 100, 101);
    wr(adr_cnt, 8'hFC);
    repeat (40) @(posedge clk);
    rchk(adr_irq, 32'h04);
    check_eq(overflow_irq, 1'h0);
    wr(adr_irq, 8'h24);
    repeat (2) @(posedge clk);
    check_eq(overflow_irq, 1'h1);
    wr(adr_irq, 8'h20);
    repeat (2) @(posedge clk);
    check_eq(overflow_irq, 1'h0);
    sleep_mode <= 1'h1;
    rd(adr_cnt);
    first = rdat[7:0];
    repeat (100) @(posedge clk);
    rchk(adr_cnt, {24'h0, first});
    sleep_mode <= 1'h0;
    $display("done timer");
  endtask : t_timer
  task automatic t_scale();
    int e;
    for (int k = 0; k < 8; k++)
    begin
      wr(adr_cfg, 8'(k));
      wr(adr_cnt, 8'h00);
      repeat (1024) @(posedge clk);
      rd(adr_cnt);
      e = 128 >> k;
      check_rng(rdat[7:0], e - 2, e + 1);
    end
    $display("done scale");
  endtask : t_scale
  task automatic t_count();
    wr(adr_cfg, 8'h28);
    wr(adr_cnt, 8'h00);
    repeat (12) @(posedge clk);
    pulses(4'h3, 1'h0);
    rchk(adr_cnt, 32'h2);
    wr(adr_cfg, 8'h38);
    wr(adr_cnt, 8'h00);
    repeat (12) @(posedge clk);
    pulses(4'h3, 1'h1);
    rchk(adr_cnt, 32'h2);
    wr(adr_cfg, 8'h20);
    wr(adr_cnt, 8'h00);
    repeat (12) @(posedge clk);
    pulses(4'h8, 1'h0);
    rchk(adr_cnt, 32'h2);
    $display("done count");
  endtask : t_count
  task automatic t_wdog();
    int b;
    watchdog_clear <= 1'h1;
    @(posedge clk);
    watchdog_clear <= 1'h0;
    wr(adr_cnt, 8'h00);
    wr(adr_cfg, 8'h0A);
    b = posts;
    tick(8);
    check_eq(posts - b, 32'h2);
    tick(3);
    watchdog_clear <= 1'h1;
    @(posedge clk);
    watchdog_clear <= 1'h0;
    tick(3);
    check_eq(posts - b, 32'h2);
    tick(1);
    check_eq(posts - b, 32'h3);
    $display("done watchdog");
  endtask : t_wdog
  task automatic results();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results
  initial
  begin
    {nrst, sleep_mode, watchdog_tick, watchdog_clear, go, slow} = 6'h0;
    req = '0;
    toggles = 4'h0;
    {fail_count, checked, posts} = {32'h0, 32'h0, 32'h0};
    repeat (12) @(posedge clk);
    nrst <= 1'h1;
    t_reset();
    t_timer();
    t_scale();
    t_count();
    t_wdog();
    results();
  end
  initial
  begin
    #200000;
    fail_count++;
    results();
  end
endmodule : tcwp_timer_bench
